// ==== tsw_config.sv ====
// Purpose: control register, alignment result and connection memory
// Assumes: one clock, synchronous reset, host strobes one cycle long
// Notes:   pins pass two flip-flops before use
// Behaviour
// - fill copies control bits 9..7 into connection word bits 15..13
// - fill clears connection word bits 12..0
// - fill starts only on rising edge of fill-go bit 6
// - whole fill completes within two frames
// - device clears fill-go when fill is finished
// - transmit drivers off when drive pin and standby bit both zero
// - rising edge of evaluation-start bit 4 begins offset measurement
// - evaluation stops when done flag rises
// - control bits 3..0 select the data-rate combination
// - connection bit 15 loops transmit channel back to receive
// - loopback only honoured for rate codes 0000, 0001, 0010
// - connection bits 14..13 select the per-channel switching mode
// - connection bits 12..8 hold the source stream number
// - connection bits 7..0 hold the source channel number
// - control bit 11 arms fill; fill-go inert when unarmed
// - done flag, result bit 12, set when measurement is valid
// - done flag cleared when evaluation-start falls
//
// The plain strobed port and the placing of the registers were decided locally.
module tsw_config
	import tsw_pkg::*;
#(
	parameter int NUM_WORDS = 256,
	parameter int FRAME_CYCLES = FRAME_CYC
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_i,
	input  wire logic [ADDR_W-1:0]    addr_i,
	input  wire logic [DATA_W-1:0]    wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [DATA_W-1:0]    rdata_o,
	input  wire logic                 output_drive_pin_i,
	input  wire logic                 ref_frame_i,
	input  wire logic                 in_frame_i,
	input  wire logic [$clog2(NUM_WORDS)-1:0] chan_idx_i,
	output tsw_cm_word_type           chan_cfg_o,
	output logic      [3:0]           rate_select_o,
	output logic                      tx_oe_o
);
	localparam int IW = $clog2(NUM_WORDS);
	localparam logic [IW-1:0] LAST_IDX = IW'(NUM_WORDS - 1);

	localparam int MAX_WORDS = FILL_FRAMES * FRAME_CYCLES;

	// refuse sizes that the one-word-per-clock sweep cannot serve in time
	if (NUM_WORDS < 2 || NUM_WORDS > MAX_WORDS) begin : g_bad_size
		$error("NUM_WORDS cannot be filled in time");
	end

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic ode_s;
	logic ref_s;
	logic inf_s;

	tsw_sync2 u_sync_ode (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.d_i        (output_drive_pin_i),
		.q_o        (ode_s)
	);
	tsw_sync2 u_sync_ref (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.d_i        (ref_frame_i),
		.q_o        (ref_s)
	);
	tsw_sync2 u_sync_inf (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.d_i        (in_frame_i),
		.q_o        (inf_s)
	);

	////////////////////////////////////////////////////////////////////
	// decode

	logic wr_ctrl;
	logic wr_cm;
	logic rd_cm;
	assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
	assign wr_cm   = wr_i && addr_i[ADDR_CM_BIT];
	assign rd_cm   = rd_i && addr_i[ADDR_CM_BIT];

	////////////////////////////////////////////////////////////////////
	// control register

	logic [DATA_W-1:0] ctrl_r;
	logic              go_d_r;
	logic              eval_d_r;
	logic              fill_busy_r;
	logic [IW-1:0]     fill_idx_r;
	logic              fill_kick;
	logic              fill_end;

	assign fill_kick = ctrl_r[CTL_FILL_GO] && !go_d_r
		&& ctrl_r[CTL_FILL_ARM] && !fill_busy_r;
	assign fill_end  = fill_busy_r && (fill_idx_r == LAST_IDX);

	// bit 10 is masked off so it always reads zero; a host write wins
	// over the self-clear so a written fill-go value is never lost
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl_r <= CTL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= wdata_i & CTL_WR_MASK;
		end else if (fill_end) begin
			ctrl_r[CTL_FILL_GO] <= 1'b0;
		end
	end

	// edge history of the two start bits
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			go_d_r   <= 1'b0;
			eval_d_r <= 1'b0;
		end else begin
			go_d_r   <= ctrl_r[CTL_FILL_GO];
			eval_d_r <= ctrl_r[CTL_EVAL];
		end
	end

	////////////////////////////////////////////////////////////////////
	// block fill sweep, one word per clock through every location

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			fill_busy_r <= 1'b0;
			fill_idx_r  <= '0;
		end else if (fill_kick) begin
			fill_busy_r <= 1'b1;
			fill_idx_r  <= '0;
		end else if (fill_end) begin
			fill_busy_r <= 1'b0;
		end else if (fill_busy_r) begin
			fill_idx_r  <= fill_idx_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// connection memory; host writes are ignored while a fill runs

	logic [DATA_W-1:0] cm_mem [NUM_WORDS];
	logic [2:0]        fill_val;
	assign fill_val = ctrl_r[CTL_FVAL_HI:CTL_FVAL_LO];

	// cleared by reset so a lookup never hands the datapath an unknown
	// word; the price is a reset on every storage flop
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				cm_mem[i] <= '0;
			end
		end else if (fill_busy_r) begin
			cm_mem[fill_idx_r] <= {fill_val, CW_LOW_CLEAR};
		end else if (wr_cm) begin
			cm_mem[addr_i[IW-1:0]] <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// frame alignment evaluation

	tsw_eval_type          ev_state_r;
	logic                  ev_done_r;
	logic [ALN_CNT_W-1:0]  ev_cnt_r;
	logic                  ref_d_r;
	logic                  inf_d_r;
	logic                  ref_rise;
	logic                  inf_rise;
	logic                  eval_rise;
	logic                  eval_fall;

	assign ref_rise  = ref_s && !ref_d_r;
	assign inf_rise  = inf_s && !inf_d_r;
	assign eval_rise = ctrl_r[CTL_EVAL] && !eval_d_r;
	assign eval_fall = !ctrl_r[CTL_EVAL] && eval_d_r;

	// edge history of the synchronised frame pulses
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ref_d_r <= 1'b0;
			inf_d_r <= 1'b0;
		end else begin
			ref_d_r <= ref_s;
			inf_d_r <= inf_s;
		end
	end

	// offset counts core cycles from reference frame to input frame,
	// saturating; half-cycle resolution is not offered
	always_ff @(posedge core_clk_i) begin
		if (rst_i || eval_fall) begin
			ev_state_r <= EV_IDLE;
			ev_done_r  <= 1'b0;
			ev_cnt_r   <= '0;
		end else begin
			case (ev_state_r)
				EV_IDLE: begin
					if (eval_rise) begin
						ev_state_r <= EV_WAIT;
						ev_cnt_r   <= '0;
					end
				end
				EV_WAIT: begin
					if (ref_rise) begin
						ev_state_r <= EV_COUNT;
					end
				end
				EV_COUNT: begin
					if (inf_rise) begin
						ev_state_r <= EV_DONE;
						ev_done_r  <= 1'b1;
					end else if (~&ev_cnt_r) begin
						ev_cnt_r <= ev_cnt_r + 1'b1;
					end
				end
				EV_DONE: begin
					ev_state_r <= EV_DONE;
				end
				default: begin
					ev_state_r <= EV_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// host read data, valid the cycle after the strobe

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (rd_cm) begin
			rdata_o <= cm_mem[addr_i[IW-1:0]];
		end else if (rd_i && addr_i == ADDR_CTRL) begin
			rdata_o <= ctrl_r;
		end else if (rd_i && addr_i == ADDR_ALIGN) begin
			rdata_o <= {3'h0, ev_done_r, 1'b0, ev_cnt_r};
		end else begin
			rdata_o <= '0;    // unmapped reads answer zero
		end
	end

	////////////////////////////////////////////////////////////////////
	// datapath-facing outputs

	logic channel_loopback_ok;
	assign channel_loopback_ok = (ctrl_r[CTL_RATE_HI:0] <= RATE_CHANNEL_LOOPBACK_MAX);

	// loopback is masked here so the datapath never sees it in modes
	// where the receive and transmit channel maps differ
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			chan_cfg_o <= '0;
		end else begin
			chan_cfg_o      <= tsw_cm_word_type'(
				cm_mem[chan_idx_i]);
			chan_cfg_o.channel_loopback <= cm_mem[chan_idx_i][DATA_W-1]
				&& channel_loopback_ok;
		end
	end

	// rate field and drive enable for the transmit pins
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rate_select_o <= '0;
			tx_oe_o       <= 1'b0;
		end else begin
			rate_select_o <= ctrl_r[CTL_RATE_HI:0];
			tx_oe_o       <= ode_s || ctrl_r[CTL_STANDBY];
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	logic [31:0] fill_cyc_r;
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !fill_busy_r) begin
			fill_cyc_r <= '0;
		end else begin
			fill_cyc_r <= fill_cyc_r + 32'h1;
		end
	end

	fill_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(fill_busy_r) |-> $past(fill_kick))
		else $error("fill began without a fill-go rising edge");

	fill_arm_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		fill_kick |=> fill_busy_r && fill_idx_r == '0)
		else $error("armed fill-go did not start a fill");

	fill_word_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		fill_busy_r |=> cm_mem[$past(fill_idx_r)]
			== {$past(fill_val), CW_LOW_CLEAR})
		else $error("filled word has wrong contents");

	fill_time_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		fill_cyc_r < 32'(FILL_FRAMES * FRAME_CYCLES))
		else $error("fill took longer than two frames");

	fill_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(fill_busy_r) && !$past(wr_ctrl) |-> !ctrl_r[CTL_FILL_GO])
		else $error("fill-go not cleared at fill end");

	fill_all_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(fill_busy_r) |-> $past(fill_idx_r) == LAST_IDX)
		else $error("fill ended before the last word");

	tx_enable_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		##1 tx_oe_o == ($past(ode_s) || $past(ctrl_r[CTL_STANDBY])))
		else $error("transmit enable does not follow pin and standby");

	eval_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ev_state_r == EV_IDLE && eval_rise && !eval_fall |=> ev_state_r == EV_WAIT)
		else $error("evaluation did not start");

	eval_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ev_done_r && ctrl_r[CTL_EVAL] ##1 !eval_fall
			|-> ev_done_r && $stable(ev_cnt_r))
		else $error("evaluation kept running after done");

	eval_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		eval_fall |=> !ev_done_r && ev_cnt_r == '0)
		else $error("done flag not cleared on start falling");

	channel_loopback_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		chan_cfg_o.channel_loopback |-> $past(channel_loopback_ok))
		else $error("loopback passed in a disallowed rate mode");

	chan_fields_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		##1 {chan_cfg_o.mode, chan_cfg_o.src_stream, chan_cfg_o.src_chan}
			== $past(cm_mem[chan_idx_i][14:0]))
		else $error("channel fields do not match the stored word");

endmodule // tsw_config

// ==== tsw_pkg.sv ====
// Purpose: shared constants and types for the switch configuration bank
// Assumes: 100 MHz core clock, 125 us frames
// Notes:   register indices and field positions live here only
package tsw_pkg;

	localparam int CLK_NS       = 10;       // core clock period
	localparam int FRAME_NS     = 125000;   // one frame
	localparam int FRAME_CYC    = FRAME_NS / CLK_NS;
	localparam int FILL_FRAMES  = 2;        // fill must finish in this many

	// register bus
	localparam int          ADDR_W      = 16;
	localparam int          DATA_W      = 16;
	localparam logic [15:0] ADDR_CTRL   = 16'h0000;
	localparam logic [15:0] ADDR_ALIGN  = 16'h0001;
	localparam int          ADDR_CM_BIT = 15;    // set: connection word

	// control register fields
	localparam int          CTL_FILL_ARM  = 11;
	localparam int          CTL_RSVD      = 10;
	localparam int          CTL_FVAL_HI   = 9;
	localparam int          CTL_FVAL_LO   = 7;
	localparam int          CTL_FILL_GO   = 6;
	localparam int          CTL_STANDBY   = 5;
	localparam int          CTL_EVAL      = 4;
	localparam int          CTL_RATE_HI   = 3;
	localparam logic [15:0] CTL_WR_MASK   = 16'h0bff;
	localparam logic [15:0] CTL_RESET     = 16'h0000;

	// alignment result register fields
	localparam int          ALN_DONE      = 12;
	localparam int          ALN_CNT_W     = 11;

	// connection word fields
	localparam int          CW_FILL_LSB   = 13;
	localparam logic [12:0] CW_LOW_CLEAR  = 13'h0000;
	localparam logic [3:0]  RATE_CHANNEL_LOOPBACK_MAX = 4'h2;   // 0000..0010 only

	typedef enum logic [1:0] {
		MODE_VAR_DELAY = 2'h0,
		MODE_CONST     = 2'h1,
		MODE_PROC      = 2'h2,
		MODE_HIZ       = 2'h3
	} tsw_mode_type;

	typedef struct packed {
		logic         channel_loopback;
		tsw_mode_type mode;
		logic [4:0]   src_stream;
		logic [7:0]   src_chan;
	} tsw_cm_word_type;

	// evaluation states, gray along idle-wait-count-done
	typedef enum logic [1:0] {
		EV_IDLE  = 2'b00,
		EV_WAIT  = 2'b01,
		EV_COUNT = 2'b11,
		EV_DONE  = 2'b10
	} tsw_eval_type;

endpackage

// ==== tsw_sync2.sv ====
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to core_clk_i
// Notes:   only the second stage is visible outside
module tsw_sync2 (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;

	// first stage feeds nothing but the second
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule // tsw_sync2

// ==== tsw_frame_model.sv ====
// Purpose: far-side frame source for the configuration bank bench
// Assumes: both frame pulses are one core cycle wide, same period
// Notes:   input frame lags the reference frame by OFFSET cycles
module tsw_frame_model #(
	parameter int FRAME  = 300,
	parameter int OFFSET = 37
) (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	output logic      ref_frame_o,
	output logic      in_frame_o
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt = 0;

	////////////////////////////////////////////////////////////////////
	// pulses start low so the synchronisers never see an unknown edge
	initial begin
		ref_frame_o = 1'b0;
		in_frame_o = 1'b0;
	end

	// one-cycle pulses: the narrowest the 2-FF front end must still catch
	always @(posedge core_clk_i) begin
		cnt <= (rst_i || cnt == FRAME - 1) ? 0 : cnt + 1;
		ref_frame_o <= !rst_i && cnt == 0;
		in_frame_o <= !rst_i && cnt == OFFSET;
	end
endmodule // tsw_frame_model

// ==== tsw_config_test.sv ====
// Purpose: self-checking bench for the switch configuration bank
// Assumes: the bench is the host, the frame model the stream side
// Notes:   frame shortened to FRM cycles, memory to 16 words
module tsw_config_test
	import tsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int FRM = 300;
	localparam int OFS = 37;

	logic            core_clk_i = 1'b0;
	logic            rst_i      = 1'b1;
	logic [15:0]     addr_i     = 16'h0000;
	logic [15:0]     wdata_i    = 16'h0000;
	logic            wr_i       = 1'b0;
	logic            rd_i       = 1'b0;
	logic            drv_pin    = 1'b0;
	logic [3:0]      idx        = 4'h0;
	logic [15:0]     rdata_o;
	tsw_cm_word_type cfg;
	logic [3:0]      rate;
	logic            tx_oe;
	logic            ref_fr;
	logic            in_fr;
	logic [15:0]     d;
	int              error_cnt  = 0;
	int              compares   = 0;
	int              n;

	////////////////////////////////////////////////////////////////////
	tsw_config #(.NUM_WORDS(16), .FRAME_CYCLES(FRM)) dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.output_drive_pin_i(drv_pin), .ref_frame_i(ref_fr),
		.in_frame_i(in_fr), .chan_idx_i(idx), .chan_cfg_o(cfg),
		.rate_select_o(rate), .tx_oe_o(tx_oe));

	tsw_frame_model #(.FRAME(FRM), .OFFSET(OFS)) far_end (
		.core_clk_i(core_clk_i), .rst_i(rst_i),
		.ref_frame_o(ref_fr), .in_frame_o(in_fr));

	// 100 MHz core clock
	always #5 core_clk_i = ~core_clk_i;

	////////////////////////////////////////////////////////////////////
	// host bus cycles, all launched right after a rising edge
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [15:0] e,
		input string nm);
		logic [15:0] v;
		rd(a, v);
		chk(nm, e, v);
	endtask

	// lookup answers one cycle after the index is taken
	task automatic lookup(input int k, input logic [15:0] e);
		@(posedge core_clk_i);
		idx <= 4'(k);
		repeat (2) @(posedge core_clk_i);
		#1 chk("chan_cfg", e, cfg);
	endtask

	function automatic logic [15:0] cw(input int m);
		return {1'b1, 2'(m), 5'(m + 17), 8'(m * 37 + 5)};
	endfunction

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// watchdog: the tests need well under 10000 cycles
	initial begin
		repeat (60000) @(posedge core_clk_i);
		error_cnt++;
		stop_test();
	end

	// test sequence
	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rdchk(ADDR_CTRL, 16'h0000, "ctrl_rst");
		rdchk(ADDR_ALIGN, 16'h0000, "align_rst");
		chk("oe_rst", 16'h0000, {15'h0, tx_oe});
		$display("test reset done");

		wr(ADDR_CTRL, 16'h002a);
		rdchk(ADDR_CTRL, 16'h002a, "ctrl_rb");
		chk("rate", 16'h000a, {12'h0, rate});
		chk("oe_standby", 16'h0001, {15'h0, tx_oe});
		wr(ADDR_ALIGN, 16'h1fff);
		rdchk(ADDR_ALIGN, 16'h0000, "align_ro");
		rdchk(16'h0002, 16'h0000, "unmapped");
		wr(ADDR_CTRL, 16'h0002);
		repeat (3) @(posedge core_clk_i);
		#1 chk("oe_off", 16'h0000, {15'h0, tx_oe});
		drv_pin <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		#1 chk("oe_pin", 16'h0001, {15'h0, tx_oe});
		$display("test control done");

		for (int m = 0; m < 4; m++) begin
			wr(16'h8000 + 16'(m), cw(m));
			rdchk(16'h8000 + 16'(m), cw(m), "cm_rb");
			lookup(m, cw(m));
		end
		wr(ADDR_CTRL, 16'h0003);
		lookup(1, cw(1) & 16'h7fff);
		$display("test connection done");

		wr(ADDR_CTRL, 16'h02c3);
		repeat (20) @(posedge core_clk_i);
		rdchk(16'h8001, cw(1), "fill_unarmed");
		wr(ADDR_CTRL, 16'h0003);
		wr(ADDR_CTRL, 16'h0ac3);
		n = 0;
		do begin
			rd(ADDR_CTRL, d);
			n += 2;
		end while (d[6] !== 1'b0 && n < 4 * FRM);
		chk("fill_time", 16'h0001, {15'h0, n <= 2 * FRM});
		chk("fill_ctrl", 16'h0a83, d);
		for (int k = 0; k < 16; k++)
			rdchk(16'h8000 + 16'(k), 16'ha000, "cm_fill");
		lookup(3, 16'h2000);
		$display("test fill done");

		// second pass restarts after start was held low a full frame
		for (int r = 0; r < 2; r++) begin
			wr(ADDR_CTRL, 16'h0013);
			n = 0;
			do begin
				rd(ADDR_ALIGN, d);
				n += 2;
			end while (d[12] !== 1'b1 && n < 4 * FRM);
			chk("eval_done", 16'h0001, {15'h0, d[12]});
			chk("eval_cnt", 16'h0001,
				{15'h0, d[10:0] >= OFS - 1 && d[10:0] <= OFS + 1});
			repeat (FRM) @(posedge core_clk_i);
			rdchk(ADDR_ALIGN, d, "eval_held");
			wr(ADDR_CTRL, 16'h0003);
			rdchk(ADDR_ALIGN, 16'h0000, "eval_clr");
			repeat (FRM) @(posedge core_clk_i);
		end
		$display("test evaluation done");
		stop_test();
	end
endmodule // tsw_config_test
